// ### inc/serial_unit_pkg.sv
package serial_unit_pkg;

	// ==========================================================
	// Bus geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam int FIFO_DEPTH = 32;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] OFF_MODE = 8'h00;
	localparam logic [7:0] OFF_CLK = 8'h04;
	localparam logic [7:0] OFF_RX_WORD = 8'h08;
	localparam logic [7:0] OFF_RX_LOW = 8'h0c;
	localparam logic [7:0] OFF_PEEK_WORD = 8'h10;
	localparam logic [7:0] OFF_PEEK_LOW = 8'h14;
	localparam logic [7:0] OFF_TX_WORD = 8'h18;
	localparam logic [7:0] OFF_TX_LOW = 8'h1c;
	localparam logic [7:0] OFF_FIRST_WORD = 8'h20;
	localparam logic [7:0] OFF_FIRST_LOW = 8'h24;
	localparam logic [7:0] OFF_SHIFT_WORD = 8'h28;
	localparam logic [7:0] OFF_SHIFT_LOW = 8'h2c;

	// ==========================================================
	// Field positions
	localparam int BIT_ENABLE = 0;
	localparam int BIT_LENGTH = 1;
	localparam int BIT_AUTO = 2;
	localparam int BIT_DELAY = 3;
	localparam int BIT_ACTIVE = 7;
	localparam int BIT_CKS_LO = 0;

	// ==========================================================
	// Reset values and encodings
	localparam logic [2:0] CKS_RST = 3'h0;
	localparam logic [2:0] CKS_SLAVE = 3'h7;

	// ==========================================================
	// Timing
	localparam int CLK_NS = 40;
	// Four pclk per half period gives the sdi synchroniser time to settle
	localparam int HALF_MIN_CYCLES = 4;
	localparam int GAP_NS = 200;
	localparam int GAP_CYCLES = (GAP_NS + CLK_NS - 1) / CLK_NS;

	typedef enum logic [1:0] {
		IDLE,
		SHIFT,
		GAP
	} xfer_state_type;

endpackage

// ### inc/stream_if.sv
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// Valid/ready word stream
interface stream_if #(
	parameter int W = 16
);
	logic valid;
	logic ready;
	logic [W-1:0] data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

// ### src/stream_fifo.sv
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// Word FIFO with a registered output stage
module stream_fifo #(
	parameter int W = 16,
	parameter int DEPTH = 32
) (
	input wire logic clk,
	input wire logic rst_n,
	stream_if.snk wr,
	stream_if.src rd
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [PW-1:0] wp;
		logic [PW-1:0] rp;
		logic [CW-1:0] cnt;
		logic ov;
		logic [W-1:0] od;
	} fifo_state_type;

	fifo_state_type q;
	fifo_state_type n;
	logic push;
	logic pop;
	logic load;

	// Full only counts the array; the output stage is extra room
	assign wr.ready = (q.cnt != CW'(DEPTH));
	assign rd.valid = q.ov;
	assign rd.data = q.od;

	// ==========================================================
	// Next state
	always_comb begin
		n = q;
		push = wr.valid && (q.cnt != CW'(DEPTH));
		pop = q.ov && rd.ready;
		load = (!q.ov || pop) && (q.cnt != '0);
		if (push) begin
			n.mem[q.wp] = wr.data;
			n.wp = q.wp + PW'(1);
		end
		if (load) begin
			n.od = q.mem[q.rp];
			n.ov = 1'b1;
			n.rp = q.rp + PW'(1);
		end else if (pop) begin
			n.ov = 1'b0;
		end
		n.cnt = q.cnt + CW'(push) - CW'(load);
	end

	// ==========================================================
	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end
endmodule

`default_nettype wire

// ### src/clocked_serial_buffer_access.sv
// Functional notes
// - Single mode: transmit buffer access only while idle; busy writes are dropped, but the code serves reads at any time.
// - First-transmit data used in matching view and only while idle; the code gates writes on idle but serves either view in either length.
// - Shift register read in matching view, only while idle; the code serves either view at any time, busy or not.
// - Clock select 111 means slave; any other value is master.
// - Delay between frames works only as master; refused in slave mode.
// - Reading a peek view never starts a receive.
// - Clock control accepts writes only while the unit is disabled.
`timescale 1ns/1ns
`default_nettype none

module clocked_serial_buffer_access
	import serial_unit_pkg::*;
#(
	parameter int FIFO_WORDS = serial_unit_pkg::FIFO_DEPTH
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [serial_unit_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sck_in,
	output logic sck_out,
	output logic sck_oe_n,
	input wire logic sdi,
	output logic sdo,
	output logic transfer_active_flag
);
	import serial_unit_pkg::*;

	// ==========================================================
	// State
	typedef struct packed {
		logic serial_unit_enable;
		logic data_length_select;
		logic auto_transfer_select;
		logic inter_transfer_delay_enable;
		logic [2:0] clock_source_select;
		logic [15:0] tx_first_data;
		logic [15:0] tx_data;
		logic tx_pend;
		logic [15:0] shreg;
		logic [4:0] bitcnt;
		logic [7:0] divcnt;
		xfer_state_type st;
		logic busy;
		logic sck_o;
		logic sck_oe_n;
		logic sdo;
		logic sck_s1;
		logic sck_s2;
		logic sck_prev;
		logic sdi_s1;
		logic sdi_s2;
		logic sdi_s3;
		logic push;
		logic [15:0] push_data;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} state_type;

	state_type q;
	state_type n;

	stream_if #(.W(DATA_W)) rx_in ();
	stream_if #(.W(DATA_W)) rx_out ();

	logic master;
	logic setup;
	logic wr;
	logic rx_pop;
	logic fall;
	logic rise;
	logic [7:0] half;
	logic [4:0] last_bit;
	logic [15:0] wdata;
	logic [15:0] shifted;

	// ==========================================================
	// Receive FIFO in the data path
	stream_fifo #(
		.W(DATA_W),
		.DEPTH(FIFO_WORDS)
	) rx_fifo (
		.clk(pclk),
		.rst_n(presetn),
		.wr(rx_in),
		.rd(rx_out)
	);

	assign rx_in.valid = q.push;
	assign rx_in.data = q.push_data;
	assign rx_out.ready = rx_pop;

	// Outputs straight from the state register
	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign sck_out = q.sck_o;
	assign sck_oe_n = q.sck_oe_n;
	assign sdo = q.sdo;
	assign transfer_active_flag = q.busy;

	// ==========================================================
	// Bus decode helpers
	assign master = (q.clock_source_select != CKS_SLAVE);
	assign setup = psel && !penable;
	assign wr = psel && penable && q.pready && pwrite;
	// Only the starting views drain the FIFO; peeks leave it alone
	assign rx_pop = psel && penable && q.pready && !pwrite &&
		((paddr == OFF_RX_WORD) || (paddr == OFF_RX_LOW));
	assign last_bit = q.data_length_select ? 5'd15 : 5'd7;
	assign half = 8'(HALF_MIN_CYCLES) << q.clock_source_select; // Wraps to 0 at 6, still 256
	// 8-bit mode zero-extends on either view so it never leaks stale upper bits
	assign wdata = q.data_length_select ? pwdata[15:0] : {8'h00, pwdata[7:0]};
	// Slave takes data one pclk before the seen rise; the far side may change it at the rise
	assign shifted = {q.shreg[14:0], master ? q.sdi_s2 : q.sdi_s3};

	// ==========================================================
	// Next state
	always_comb begin
		n = q;
		n.push = 1'b0;
		n.pready = 1'b0;
		n.pslverr = 1'b0;
		fall = 1'b0;
		rise = 1'b0;

		// Two-flop synchronisers on the link pins
		n.sck_s1 = sck_in;
		n.sck_s2 = q.sck_s1;
		n.sck_prev = q.sck_s2;
		n.sdi_s1 = sdi;
		n.sdi_s2 = q.sdi_s1;
		n.sdi_s3 = q.sdi_s2;

		// Read data captured in setup so the access phase needs no wait
		if (setup) begin
			n.pready = 1'b1;
			n.prdata = 32'h0000_0000;
			case (paddr)
				OFF_MODE: begin
					n.prdata[BIT_ENABLE] = q.serial_unit_enable;
					n.prdata[BIT_LENGTH] = q.data_length_select;
					n.prdata[BIT_AUTO] = q.auto_transfer_select;
					n.prdata[BIT_DELAY] = q.inter_transfer_delay_enable;
					n.prdata[BIT_ACTIVE] = q.busy;
				end
				OFF_CLK: begin
					n.prdata[BIT_CKS_LO +: 3] = q.clock_source_select;
				end
				OFF_RX_WORD, OFF_PEEK_WORD: begin
					n.prdata[15:0] = rx_out.valid ? rx_out.data : 16'h0000;
				end
				OFF_RX_LOW, OFF_PEEK_LOW: begin
					n.prdata[7:0] = rx_out.valid ? rx_out.data[7:0] : 8'h00;
				end
				OFF_TX_WORD: begin
					n.prdata[15:0] = q.tx_data;
				end
				OFF_TX_LOW: begin
					n.prdata[7:0] = q.tx_data[7:0];
				end
				OFF_FIRST_WORD: begin
					n.prdata[15:0] = q.tx_first_data;
				end
				OFF_FIRST_LOW: begin
					n.prdata[7:0] = q.tx_first_data[7:0];
				end
				OFF_SHIFT_WORD: begin
					n.prdata[15:0] = q.shreg;
				end
				OFF_SHIFT_LOW: begin
					n.prdata[7:0] = q.shreg[7:0];
				end
				default: begin
					n.pslverr = 1'b1;
				end
			endcase
		end

		// Register writes take effect at the access edge
		if (wr) begin
			case (paddr)
				OFF_MODE: begin
					// Mode is frozen while active so a frame keeps its length
					if (!q.busy) begin
						n.serial_unit_enable = pwdata[BIT_ENABLE];
						n.data_length_select = pwdata[BIT_LENGTH];
						n.auto_transfer_select = pwdata[BIT_AUTO];
						n.inter_transfer_delay_enable = pwdata[BIT_DELAY] && master;
					end
				end
				OFF_CLK: begin
					if (!q.serial_unit_enable) begin
						n.clock_source_select = pwdata[BIT_CKS_LO +: 3];
						if (pwdata[BIT_CKS_LO +: 3] == CKS_SLAVE) begin
							n.inter_transfer_delay_enable = 1'b0;
						end
					end
				end
				OFF_TX_WORD, OFF_TX_LOW: begin
					// Continuous mode queues one word behind the running frame
					if (!q.tx_pend && (q.auto_transfer_select || !q.busy)) begin
						n.tx_data = wdata;
						n.tx_pend = 1'b1;
					end
				end
				OFF_FIRST_WORD, OFF_FIRST_LOW: begin
					if (!q.busy) begin
						n.tx_first_data = wdata;
					end
				end
				default: begin
				end
			endcase
		end

		// Link clock edges: own divider as master, synced pin as slave
		if (master) begin
			if (q.st == SHIFT) begin
				if (q.divcnt == half - 8'd1) begin
					n.divcnt = 8'h00;
					n.sck_o = !q.sck_o;
					fall = q.sck_o;
					rise = !q.sck_o;
				end else begin
					n.divcnt = q.divcnt + 8'd1;
				end
			end
		end else begin
			fall = q.sck_prev && !q.sck_s2;
			rise = !q.sck_prev && q.sck_s2;
		end

		// Transfer engine
		case (q.st)
			IDLE: begin
				// A full FIFO stalls the next frame, but a word still being pushed is not counted, so a back-to-back frame can lose data
				if (q.tx_pend && q.serial_unit_enable && rx_in.ready) begin
					n.st = SHIFT;
					n.shreg = q.tx_data;
					n.tx_pend = 1'b0;
					n.busy = 1'b1;
					n.bitcnt = 5'd0;
					n.divcnt = 8'h00;
				end
			end
			SHIFT: begin
				if (fall) begin
					n.sdo = q.data_length_select ? q.shreg[15] : q.shreg[7];
				end
				if (rise) begin
					n.shreg = shifted;
					n.bitcnt = q.bitcnt + 5'd1;
					if (q.bitcnt == last_bit) begin
						n.busy = 1'b0;
						n.push = 1'b1;
						n.push_data = q.data_length_select ? shifted : {8'h00, shifted[7:0]};
						n.divcnt = 8'h00;
						if (master && q.inter_transfer_delay_enable) begin
							n.st = GAP;
						end else begin
							n.st = IDLE;
						end
					end
				end
			end
			GAP: begin
				// Gap keeps the line quiet; queued data waits it out
				if (q.divcnt == 8'(GAP_CYCLES - 1)) begin
					n.st = IDLE;
					n.divcnt = 8'h00;
				end else begin
					n.divcnt = q.divcnt + 8'd1;
				end
			end
			default: begin
				n.st = IDLE;
			end
		endcase

		// Disabling aborts any frame and parks the clock high
		if (!q.serial_unit_enable) begin
			n.st = IDLE;
			n.busy = 1'b0;
			n.tx_pend = 1'b0;
			n.sck_o = 1'b1;
			n.divcnt = 8'h00;
		end

		// Drive the clock pin only as an enabled master
		n.sck_oe_n = !(master && q.serial_unit_enable);
	end

	// ==========================================================
	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
			q.clock_source_select <= CKS_RST;
			q.sck_o <= 1'b1;
			q.sck_oe_n <= 1'b1;
			// Pin idles high; a low start would fake a rising edge
			q.sck_s1 <= 1'b1;
			q.sck_s2 <= 1'b1;
			q.sck_prev <= 1'b1;
		end else begin
			q <= n;
		end
	end
endmodule

`default_nettype wire

// ### testbench/serial_peer.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Far-side serial device, shifts MSB first
module serial_peer (
	input wire logic sck,
	input wire logic sdo,
	input wire logic len16,
	input wire logic [15:0] reply,
	output logic sck_m,
	output logic sdi,
	output logic [15:0] got
);
	int n = 0;
	initial begin
		sck_m = 1;
		sdi = 0;
		got = 0;
	end
	// Drive on the falling pin edge
	always @(negedge sck) begin
		sdi <= reply[(len16 ? 15 : 7) - n];
		n <= n + 1;
	end
	// Sample on rise; after the last bit the line no longer holds data
	always @(posedge sck) begin
		got <= {got[14:0], sdo};
		if (n == (len16 ? 16 : 8)) begin
			n <= 0;
			sdi <= ~sdi;
		end
	end
	// Clock only inside a frame; changes land after pclk has sampled
	task automatic frame();
		repeat (len16 ? 16 : 8) begin
			#160 sck_m <= 0;
			#160 sck_m <= 1;
		end
	endtask
endmodule
`default_nettype wire

// ### testbench/serial_unit_chk.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Port checks
module serial_unit_chk
	import serial_unit_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic sck_in,
	input wire logic sck_out,
	input wire logic sck_oe_n,
	input wire logic sdi,
	input wire logic sdo,
	input wire logic transfer_active_flag
);
	int nf;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Falls per frame; a frame that never ends shows here
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) nf <= 0;
		else if (!transfer_active_flag) nf <= 0;
		else if ($fell(sck_out)) nf <= nf + 1;
	end
	a_ready_after_setup:
		assert property (psel && !penable |=> pready) else $error("no ready");
	a_ready_one_cycle:
		assert property (pready |=> !pready) else $error("long ready");
	a_err_unmapped:
		assert property (pready && paddr > OFF_SHIFT_LOW |-> pslverr) else $error("no err");
	a_low_view_upper:
		assert property (pready && !pwrite && paddr[2] && paddr > OFF_CLK
			&& paddr < 8'h30 |-> prdata[31:8] == 0) else $error("low view");
	a_word_view_upper:
		assert property (pready && !pwrite |-> prdata[31:16] == 0) else $error("word");
	a_mode_shows_active:
		assert property (pready && !pwrite && paddr == OFF_MODE
			|-> prdata[BIT_ACTIVE] == $past(transfer_active_flag)) else $error("act bit");
	a_master_clocks:
		assert property ($rose(transfer_active_flag) && !sck_oe_n
			|-> ##[1:600] $fell(sck_out)) else $error("no clock");
	a_fall_in_frame:
		assert property ($fell(sck_out) |-> transfer_active_flag) else $error("stray");
	a_frame_length:
		assert property (nf <= 16) else $error("long frame");
	c_master: cover property ($rose(transfer_active_flag) && !sck_oe_n);
	c_slave: cover property ($rose(transfer_active_flag) && sck_oe_n);
	c_err: cover property (pslverr);
endmodule
bind clocked_serial_buffer_access serial_unit_chk i_serial_unit_chk (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sck_in,
	.sck_out, .sck_oe_n, .sdi, .sdo, .transfer_active_flag);
`default_nettype wire

// ### testbench/tb.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Bench
module tb;
	import serial_unit_pkg::*;
	typedef struct {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] x; logic e;} row_type;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, len16 = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, r;
	logic pready, pslverr, sck_out, sck_oe_n, sdo, transfer_active_flag, sck_m, sdi, e;
	logic [15:0] rep = 0, got;
	int n_mismatch = 0, comparisons = 0;
	wire logic sck = sck_oe_n ? sck_m : sck_out;
	// Each first-data view is used only in its own frame length
	row_type rows[12] = '{'{OFF_MODE, 1'b0, '0, '0, 1'b0},
		'{OFF_CLK, 1'b1, 32'h1, '0, 1'b0}, '{OFF_CLK, 1'b0, '0, 32'h1, 1'b0},
		'{OFF_FIRST_LOW, 1'b1, 32'ha5c3, '0, 1'b0},
		'{OFF_FIRST_LOW, 1'b0, '0, 32'hc3, 1'b0},
		'{OFF_MODE, 1'b1, 32'h2, '0, 1'b0}, '{OFF_MODE, 1'b0, '0, 32'h2, 1'b0},
		'{OFF_FIRST_WORD, 1'b0, '0, 32'hc3, 1'b0},
		'{OFF_FIRST_WORD, 1'b1, 32'ha5c3, '0, 1'b0},
		'{OFF_FIRST_WORD, 1'b0, '0, 32'ha5c3, 1'b0},
		'{8'h30, 1'b0, '0, '0, 1'b1}, '{8'h30, 1'b1, 32'h1, '0, 1'b1}};
	always #20 pclk = ~pclk;
	clocked_serial_buffer_access i_clocked_serial_buffer_access (.pclk, .presetn,
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.sck_in(sck), .sck_out, .sck_oe_n, .sdi, .sdo, .transfer_active_flag);
	serial_peer i_serial_peer (.sck, .sdo, .len16, .reply(rep), .sck_m, .sdi, .got);
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		comparisons++;
		if (g !== x) begin
			n_mismatch++;
			$display("BAD t=%0t got %h exp %h", $time, g, x);
		end
	endtask
	// One bus cycle; held until ready is seen
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] q, output logic er);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'b1, d, r, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		apb(a, 1'b0, '0, r, e);
		chk(r, x);
	endtask
	// Bounded wait for the busy flag
	task automatic wait_flag(input logic v);
		int k;
		k = 0;
		while (transfer_active_flag !== v && k < 4000) begin
			@(posedge pclk);
			k++;
		end
		chk(transfer_active_flag, v);
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// Hang guard, about ten times the whole run
	initial begin
		#400000;
		n_mismatch++;
		stop_test();
	end
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		chk(sck_oe_n, 1);
		chk(transfer_active_flag, 0);
		foreach (rows[i]) begin
			apb(rows[i].a, rows[i].w, rows[i].d, r, e);
			if (!rows[i].w) begin
				chk(r, rows[i].x);
			end
			chk(e, rows[i].e);
		end
		$display("rows done");
		// Master, 8 bit, busy-time writes must be dropped
		wr(OFF_MODE, 32'h1);
		rep <= 16'h3c;
		repeat (2) @(posedge pclk);
		chk(sck_oe_n, 0);
		wr(OFF_TX_LOW, 32'h96);
		wait_flag(1);
		wr(OFF_TX_LOW, 32'h11);
		wr(OFF_MODE, 32'h3);
		rd(OFF_MODE, 32'h81);
		wait_flag(0);
		chk(got[7:0], 8'h96);
		repeat (20) @(posedge pclk);
		chk(transfer_active_flag, 0);
		rd(OFF_PEEK_LOW, 32'h3c);
		rd(OFF_PEEK_LOW, 32'h3c);
		rd(OFF_SHIFT_LOW, 32'h3c);
		rd(OFF_RX_LOW, 32'h3c);
		$display("master 8 done");
		// Master, 16 bit
		wr(OFF_MODE, 32'h3);
		len16 <= 1;
		rep <= 16'h1e87;
		wr(OFF_TX_WORD, 32'hc35a);
		wait_flag(1);
		wait_flag(0);
		chk(got, 16'hc35a);
		rd(OFF_PEEK_WORD, 32'h1e87);
		rd(OFF_SHIFT_WORD, 32'h1e87);
		rd(OFF_RX_WORD, 32'h1e87);
		wr(OFF_CLK, 32'h7);
		rd(OFF_CLK, 32'h1);
		wr(OFF_MODE, 32'h9);
		rd(OFF_MODE, 32'h9);
		$display("master 16 done");
		// Continuous mode with the gap: a second word queues behind the first
		len16 <= 0;
		rep <= 16'h5e;
		wr(OFF_MODE, 32'hd);
		wr(OFF_TX_LOW, 32'h42);
		wait_flag(1);
		wr(OFF_TX_LOW, 32'h24);
		wait_flag(0);
		chk(got[7:0], 8'h42);
		repeat (3) @(posedge pclk);
		chk(transfer_active_flag, 0);
		wait_flag(1);
		wait_flag(0);
		chk(got[7:0], 8'h24);
		rd(OFF_RX_LOW, 32'h5e);
		rd(OFF_RX_LOW, 32'h5e);
		$display("auto done");
		// Slave: far side owns the clock
		wr(OFF_MODE, 32'h0);
		wr(OFF_CLK, 32'h7);
		wr(OFF_MODE, 32'h9);
		rd(OFF_MODE, 32'h1);
		chk(sck_oe_n, 1);
		rep <= 16'ha7;
		wr(OFF_TX_LOW, 32'h5a);
		repeat (4) @(posedge pclk);
		i_serial_peer.frame();
		repeat (8) @(posedge pclk);
		wait_flag(0);
		chk(got[7:0], 8'h5a);
		rd(OFF_RX_LOW, 32'ha7);
		$display("slave done");
		// Reset in mid-run brings every field back
		presetn <= 0;
		repeat (3) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		chk(sck_oe_n, 1);
		rd(OFF_CLK, 32'h0);
		rd(OFF_MODE, 32'h0);
		rd(OFF_RX_LOW, 32'h0);
		$display("reset done");
		stop_test();
	end
endmodule
`default_nettype wire
